// ### rtl/cacc_core.sv
// Two-module counter array with capture, compare and PWM over AXI4-Lite
//
// Summary of operation
// - 16-bit count in two bytes, reset zero
// - Module byte pair holds capture/compare value
// - In PWM the pair sets duty cycle
// - Compare bytes reset zero at fixed indices
// - Width select 00=8,01=7,10=6,11=8 bits
// - Aux bits 5:2 reserved, bits 1:0 extend
// - Comparator plus pulse mode gives plain PWM
// - PWM with rising-edge flag
// - PWM with falling-edge flag
// - PWM with flag on both edges
// - Rising pin edge captures the count
// - Falling pin edge captures the count
// - Any pin transition captures the count
// - Comparator plus match is software timer
// - Adding pin flip gives high-speed output
// - Rollover sets sticky overflow flag, interrupt
// - Capture latches count and sets event flag
// - Pin flip toggles pin on each match
// - Counter counts only while run bit set
`include "cacc_defs.svh"
`default_nettype none
module cacc_core (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic timer0Tick,
  input wire logic extCountPin,
  input wire logic [1:0] modulePinIn,
  output logic [1:0] modulePinOut,
  output logic [1:0] modulePinOe,
  output logic arrayIrq
);
  import cacc_pkg::*;

  cacc_state_t q;
  cacc_state_t s;
  logic countTick;
  logic wrFire;
  logic [1:0] capEv;
  logic [1:0] matchEv;
  logic [1:0] pwmOut;

  // Divider limit for each count source
  function automatic logic [3:0] divLimit(input cacc_src_t src);
    case (src)
      CACC_SRC_DIV12: divLimit = `CACC_DIV12;
      CACC_SRC_DIV2: divLimit = `CACC_DIV2;
      CACC_SRC_DIV4: divLimit = `CACC_DIV4;
      CACC_SRC_DIV6: divLimit = `CACC_DIV6;
      CACC_SRC_DIV8: divLimit = `CACC_DIV8;
      default: divLimit = `CACC_DIV1;
    endcase
  endfunction : divLimit

  // PWM resolution mask from the width select
  function automatic logic [7:0] maskFor(input logic [1:0] width);
    case (width)
      2'b01: maskFor = 8'h7F;
      2'b10: maskFor = 8'h3F;
      default: maskFor = 8'hFF;
    endcase
  endfunction : maskFor

  // Word index of a byte address, valid only when aligned
  function automatic logic [8:0] wordIdx(input logic [11:0] addr);
    wordIdx = {addr[11:10] == 2'b00 && addr[1:0] == 2'b00, addr[9:2]};
  endfunction : wordIdx

  // Whether an index names a register
  function automatic logic isMapped(input logic [7:0] idx);
    case (idx)
      `CACC_IDX_CTRL, `CACC_IDX_SRC, `CACC_IDX_MODE0, `CACC_IDX_MODE1,
      `CACC_IDX_CNT_LO, `CACC_IDX_CAP0_LO, `CACC_IDX_CAP1_LO,
      `CACC_IDX_AUX0, `CACC_IDX_AUX1, `CACC_IDX_CNT_HI,
      `CACC_IDX_CAP0_HI, `CACC_IDX_CAP1_HI: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction : isMapped

  // Count enable and bus write strobe
  assign countTick = q.runBit && (q.divCnt == divLimit(q.cps) &&
    q.cps != CACC_SRC_TMR0 && q.cps != CACC_SRC_EXT ||
    q.cps == CACC_SRC_TMR0 && timer0Tick ||
    q.cps == CACC_SRC_EXT && q.eciS2 && !q.eciPrev);
  assign wrFire = q.awGot && q.wGot && !q.bvalid;

  // Bus handshakes and outputs
  assign awready = !q.awGot && !q.bvalid;
  assign wready = !q.wGot && !q.bvalid;
  assign arready = !q.rvalid;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = {24'h00_0000, q.rdata};
  assign arrayIrq = (q.ovfFlag && q.ecf) ||
    (q.mods[0].ccf && q.mods[0].mode[`CACC_ECCF]) ||
    (q.mods[1].ccf && q.mods[1].mode[`CACC_ECCF]);

  // Pin drive: PWM level or toggle register
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      modulePinOe[i] = q.mods[i].mode[`CACC_ECOM] &&
        (q.mods[i].mode[`CACC_PWM] || q.mods[i].mode[`CACC_TOG]);
      modulePinOut[i] = q.mods[i].mode[`CACC_PWM] ? q.mods[i].pwmLvl :
        q.mods[i].pinQ;
    end
  end

  // Next state of the whole block
  always_comb begin
    logic [15:0] cnt;
    logic [7:0] mask;
    logic [7:0] lowM;
    logic rise;
    logic fall;
    logic isPwm;
    logic isCap;
    logic pwmRise;
    logic cfSet;
    logic [1:0] ccfSet;
    logic [8:0] rIdx;
    logic [8:0] wIdx;
    cnt = {q.cntHi, q.cntLo};
    mask = 8'h00;
    lowM = 8'h00;
    rise = 1'b0;
    fall = 1'b0;
    isPwm = 1'b0;
    isCap = 1'b0;
    pwmRise = 1'b0;
    cfSet = 1'b0;
    ccfSet = 2'b00;
    rIdx = wordIdx(araddr);
    wIdx = wordIdx(awaddr);
    capEv = 2'b00;
    matchEv = 2'b00;
    pwmOut = 2'b00;
    s = q;
    // Count source synchronisers and divider
    s.eciS1 = extCountPin;
    s.eciS2 = q.eciS1;
    s.eciPrev = q.eciS2;
    s.divCnt = (q.divCnt >= divLimit(q.cps)) ? 4'h0 : q.divCnt + 4'h1;
    // Shared time base
    if (countTick) begin
      {s.cntHi, s.cntLo} = cnt + 16'h0001;
      cfSet = (cnt == 16'hFFFF);
    end
    for (int i = 0; i < 2; i++) begin
      s.mods[i].pinS1 = modulePinIn[i];
      s.mods[i].pinS2 = q.mods[i].pinS1;
      s.mods[i].pinPrev = q.mods[i].pinS2;
      rise = q.mods[i].pinS2 && !q.mods[i].pinPrev;
      fall = !q.mods[i].pinS2 && q.mods[i].pinPrev;
      isPwm = q.mods[i].mode[`CACC_ECOM] && q.mods[i].mode[`CACC_PWM];
      isCap = !q.mods[i].mode[`CACC_PWM] && !q.mods[i].mode[`CACC_MAT] &&
        !q.mods[i].mode[`CACC_TOG];
      // PWM compare against the masked low count
      mask = maskFor(q.mods[i].width);
      lowM = q.cntLo & mask;
      pwmOut[i] = {1'b0, lowM} >=
        {q.mods[i].epcL, q.mods[i].capL & mask};
      if (isPwm) begin
        s.mods[i].pwmLvl = pwmOut[i];
        pwmRise = pwmOut[i] && !q.mods[i].pwmLvl;
        if (q.mods[i].mode[`CACC_CAPP] && pwmRise) begin
          ccfSet[i] = 1'b1;
        end
        if (q.mods[i].mode[`CACC_CAPN] && !pwmOut[i] &&
            q.mods[i].pwmLvl) begin
          ccfSet[i] = 1'b1;
        end
        if (countTick && lowM == mask) begin
          s.mods[i].capL = q.mods[i].capH;
          s.mods[i].epcL = q.mods[i].epcH;
        end
      end else begin
        s.mods[i].pwmLvl = 1'b0;
      end
      // Capture on the selected pin edge
      if (isCap && ((q.mods[i].mode[`CACC_CAPP] && rise) ||
          (q.mods[i].mode[`CACC_CAPN] && fall))) begin
        capEv[i] = 1'b1;
        {s.mods[i].capH, s.mods[i].capL} = cnt;
        ccfSet[i] = 1'b1;
      end
      // Match of count against the module pair
      if (q.mods[i].mode[`CACC_ECOM] && !q.mods[i].mode[`CACC_PWM] &&
          countTick && cnt == {q.mods[i].capH, q.mods[i].capL}) begin
        matchEv[i] = 1'b1;
        if (q.mods[i].mode[`CACC_MAT]) begin
          ccfSet[i] = 1'b1;
        end
        if (q.mods[i].mode[`CACC_TOG]) begin
          s.mods[i].pinQ = !q.mods[i].pinQ;
        end
      end
      s.mods[i].ccf = q.mods[i].ccf || ccfSet[i];
    end
    s.ovfFlag = q.ovfFlag || cfSet;
    // Write channel capture
    if (awvalid && awready) begin
      s.awGot = 1'b1;
      s.awIdx = wIdx[7:0];
      s.awOk = wIdx[8] && isMapped(wIdx[7:0]);
    end
    if (wvalid && wready) begin
      s.wGot = 1'b1;
      s.wByte = wdata[7:0];
      s.wLane = wstrb[0];
    end
    // Register write; hardware set wins over a clear
    if (wrFire) begin
      s.awGot = 1'b0;
      s.wGot = 1'b0;
      s.bvalid = 1'b1;
      s.bresp = q.awOk ? `CACC_RESP_OK : `CACC_RESP_ERR;
      if (q.awOk && q.wLane) begin
        case (q.awIdx)
          `CACC_IDX_CTRL: begin
            s.ovfFlag = q.wByte[`CACC_OVF_BIT] || cfSet;
            s.runBit = q.wByte[`CACC_RUN_BIT];
            s.mods[1].ccf = q.wByte[1] || ccfSet[1];
            s.mods[0].ccf = q.wByte[0] || ccfSet[0];
          end
          `CACC_IDX_SRC: begin
            s.cps = cacc_src_t'(q.wByte[`CACC_CPS_LSB +: 3]);
            s.ecf = q.wByte[`CACC_ECF];
          end
          `CACC_IDX_MODE0: s.mods[0].mode = q.wByte[6:0];
          `CACC_IDX_MODE1: s.mods[1].mode = q.wByte[6:0];
          `CACC_IDX_CNT_LO: s.cntLo = q.wByte;
          `CACC_IDX_CNT_HI: s.cntHi = q.wByte;
          `CACC_IDX_CAP0_LO: s.mods[0].capL = q.wByte;
          `CACC_IDX_CAP0_HI: s.mods[0].capH = q.wByte;
          `CACC_IDX_CAP1_LO: s.mods[1].capL = q.wByte;
          `CACC_IDX_CAP1_HI: s.mods[1].capH = q.wByte;
          `CACC_IDX_AUX0: begin
            s.mods[0].width = q.wByte[7:6];
            {s.mods[0].epcH, s.mods[0].epcL} = q.wByte[1:0];
          end
          `CACC_IDX_AUX1: begin
            s.mods[1].width = q.wByte[7:6];
            {s.mods[1].epcH, s.mods[1].epcL} = q.wByte[1:0];
          end
          default: s.bresp = `CACC_RESP_ERR;
        endcase
      end
    end
    if (q.bvalid && bready) begin
      s.bvalid = 1'b0;
    end
    // Register read
    if (q.rvalid && rready) begin
      s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s.rvalid = 1'b1;
      s.rresp = (rIdx[8] && isMapped(rIdx[7:0])) ? `CACC_RESP_OK :
        `CACC_RESP_ERR;
      case (rIdx[8] ? rIdx[7:0] : 8'h00)
        `CACC_IDX_CTRL: s.rdata = {q.ovfFlag, q.runBit, 4'h0,
          q.mods[1].ccf, q.mods[0].ccf};
        `CACC_IDX_SRC: s.rdata = {4'h0, q.cps, q.ecf};
        `CACC_IDX_MODE0: s.rdata = {1'b0, q.mods[0].mode};
        `CACC_IDX_MODE1: s.rdata = {1'b0, q.mods[1].mode};
        `CACC_IDX_CNT_LO: s.rdata = q.cntLo;
        `CACC_IDX_CNT_HI: s.rdata = q.cntHi;
        `CACC_IDX_CAP0_LO: s.rdata = q.mods[0].capL;
        `CACC_IDX_CAP0_HI: s.rdata = q.mods[0].capH;
        `CACC_IDX_CAP1_LO: s.rdata = q.mods[1].capL;
        `CACC_IDX_CAP1_HI: s.rdata = q.mods[1].capH;
        `CACC_IDX_AUX0: s.rdata = {q.mods[0].width, 4'h0, q.mods[0].epcH,
          q.mods[0].epcL};
        `CACC_IDX_AUX1: s.rdata = {q.mods[1].width, 4'h0, q.mods[1].epcH,
          q.mods[1].epcL};
        default: s.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Time base and overflow flag
  overflow_sets_a: assert property (
    countTick && {q.cntHi, q.cntLo} == 16'hFFFF |=> q.ovfFlag)
    else $error("overflow did not set flag");
  flag_sticky_a: assert property (
    q.ovfFlag && !wrFire |=> q.ovfFlag)
    else $error("overflow flag dropped without write");
  counter_hold_a: assert property (
    !q.runBit && !wrFire |=> $stable({q.cntHi, q.cntLo}))
    else $error("counter moved while stopped");
  count_step_a: assert property (
    countTick && !wrFire |=>
    {q.cntHi, q.cntLo} == $past({q.cntHi, q.cntLo}) + 16'h0001)
    else $error("counter did not step by one");
  irq_gate_a: assert property (
    q.ovfFlag && q.ecf |-> arrayIrq)
    else $error("overflow interrupt not raised");

  // Capture, match and toggle
  capture_latch_a: assert property (
    capEv[0] && !wrFire |=> {q.mods[0].capH, q.mods[0].capL} ==
    $past({q.cntHi, q.cntLo}) && q.mods[0].ccf)
    else $error("capture did not latch count");
  timer_flag_a: assert property (
    matchEv[0] && q.mods[0].mode[`CACC_MAT] |=> q.mods[0].ccf)
    else $error("match did not set event flag");
  toggle_match_a: assert property (
    matchEv[1] && q.mods[1].mode[`CACC_TOG] |=>
    q.mods[1].pinQ != $past(q.mods[1].pinQ))
    else $error("pin did not toggle on match");

  // PWM level and edge flags of module 0
  pwm_six_bit_a: assert property (
    q.mods[0].mode[`CACC_ECOM] && q.mods[0].mode[`CACC_PWM] &&
    q.mods[0].width == 2'b10 && !q.mods[0].epcL && !wrFire &&
    q.cntLo[5:0] < q.mods[0].capL[5:0] |=> !modulePinOut[0])
    else $error("six-bit pwm level wrong");
  pwm_eight_bit_a: assert property (
    q.mods[0].mode[`CACC_ECOM] && q.mods[0].mode[`CACC_PWM] &&
    q.mods[0].width == 2'b00 && !q.mods[0].epcL && !wrFire &&
    q.cntLo >= q.mods[0].capL |=> modulePinOut[0])
    else $error("eight-bit pwm level wrong");
  pwm_quiet_a: assert property (
    q.mods[0].mode == 7'h42 && !q.mods[0].ccf && !wrFire |=>
    !q.mods[0].ccf)
    else $error("plain pwm set an event flag");
  pwm_rise_a: assert property (
    q.mods[0].mode[`CACC_ECOM] && q.mods[0].mode[`CACC_PWM] &&
    q.mods[0].mode[`CACC_CAPP] && pwmOut[0] && !q.mods[0].pwmLvl
    |=> q.mods[0].ccf)
    else $error("pwm rise did not set flag");
  pwm_fall_a: assert property (
    q.mods[0].mode[`CACC_ECOM] && q.mods[0].mode[`CACC_PWM] &&
    q.mods[0].mode[`CACC_CAPN] && !pwmOut[0] && q.mods[0].pwmLvl
    |=> q.mods[0].ccf)
    else $error("pwm fall did not set flag");

  // Idle module and bus response
  idle_module_a: assert property (
    q.mods[0].mode == `CACC_RST_MODE |->
    !modulePinOe[0] && !capEv[0] && !matchEv[0])
    else $error("idle module acted");
  idle_flag_a: assert property (
    q.mods[0].mode == `CACC_RST_MODE && !q.mods[0].ccf && !wrFire |=>
    !q.mods[0].ccf)
    else $error("idle module set a flag");
  bresp_hold_a: assert property (q.bvalid && !bready |=> q.bvalid)
    else $error("write response dropped early");
endmodule : cacc_core
`default_nettype wire

// ### rtl/cacc_defs.svh
// Register indices, field positions, reset values and divider counts
`ifndef CACC_DEFS_SVH
`define CACC_DEFS_SVH
`define CACC_IDX_CTRL 8'hD8
`define CACC_IDX_SRC 8'hD9
`define CACC_IDX_MODE0 8'hDA
`define CACC_IDX_MODE1 8'hDB
`define CACC_IDX_CNT_LO 8'hE9
`define CACC_IDX_CAP0_LO 8'hEA
`define CACC_IDX_CAP1_LO 8'hEB
`define CACC_IDX_AUX0 8'hF2
`define CACC_IDX_AUX1 8'hF3
`define CACC_IDX_CNT_HI 8'hF9
`define CACC_IDX_CAP0_HI 8'hFA
`define CACC_IDX_CAP1_HI 8'hFB
`define CACC_RST_BYTE 8'h00
`define CACC_RST_MODE 7'h00
// Mode register fields
`define CACC_ECOM 6
`define CACC_CAPP 5
`define CACC_CAPN 4
`define CACC_MAT 3
`define CACC_TOG 2
`define CACC_PWM 1
`define CACC_ECCF 0
// Control and clock-select fields
`define CACC_OVF_BIT 7
`define CACC_RUN_BIT 6
`define CACC_ECF 0
`define CACC_CPS_LSB 1
// Divider limits (count minus one)
`define CACC_DIV12 4'hB
`define CACC_DIV2 4'h1
`define CACC_DIV4 4'h3
`define CACC_DIV6 4'h5
`define CACC_DIV8 4'h7
`define CACC_DIV1 4'h0
`define CACC_RESP_OK 2'b00
`define CACC_RESP_ERR 2'b10
`endif

// ### rtl/cacc_pkg.sv
// Types shared by the counter array
`default_nettype none
package cacc_pkg;
  typedef enum logic [2:0] {
    CACC_SRC_DIV12 = 3'b000,
    CACC_SRC_DIV2 = 3'b001,
    CACC_SRC_TMR0 = 3'b010,
    CACC_SRC_EXT = 3'b011,
    CACC_SRC_DIV1 = 3'b100,
    CACC_SRC_DIV4 = 3'b101,
    CACC_SRC_DIV6 = 3'b110,
    CACC_SRC_DIV8 = 3'b111
  } cacc_src_t;
  typedef struct packed {
    logic [6:0] mode;
    logic [1:0] width;
    logic epcH;
    logic epcL;
    logic [7:0] capL;
    logic [7:0] capH;
    logic ccf;
    logic pinQ;
    logic pwmLvl;
    logic pinS1;
    logic pinS2;
    logic pinPrev;
  } cacc_mod_t;
  typedef struct packed {
    cacc_mod_t [1:0] mods;
    logic [7:0] cntLo;
    logic [7:0] cntHi;
    logic ovfFlag;
    logic runBit;
    logic ecf;
    cacc_src_t cps;
    logic [3:0] divCnt;
    logic eciS1;
    logic eciS2;
    logic eciPrev;
    logic awGot;
    logic wGot;
    logic [7:0] awIdx;
    logic awOk;
    logic [7:0] wByte;
    logic wLane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } cacc_state_t;
endpackage : cacc_pkg
`default_nettype wire

// ### verif/cacc_core_tb.sv
// Self-checking bench for the counter array core
`default_nettype none
module cacc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, timer0Tick, arrayIrq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, pinIn, pinOut, pinOe, extLevel;
  logic [7:0] rd;
  int n_mismatch, check_count;
  localparam logic [7:0] RST_IDX [6] = '{8'hE9, 8'hF9, 8'hEA, 8'hFA,
    8'hEB, 8'hFB};
  localparam logic [7:0] CAP_MODE [4] = '{8'h20, 8'h10, 8'h30, 8'h00};
  localparam logic [7:0] EDGE_MODE [3] = '{8'h63, 8'h53, 8'h73};

  cacc_core dut (.clock(clock), .sys_rst(sys_rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .timer0Tick(timer0Tick), .extCountPin(1'b0), .modulePinIn(pinIn),
    .modulePinOut(pinOut), .modulePinOe(pinOe), .arrayIrq(arrayIrq));

  cacc_pin_model pins (.clock(clock), .pinOut(pinOut), .pinOe(pinOe),
    .extLevel(extLevel), .pinIn(pinIn));

  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic close_out;
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang;
    n_mismatch++;
    $display("FAIL %0t bus answer never came", $time);
    close_out();
  endtask : hang

  // Bus write: address and data offered together, response awaited
  task automatic wr(input logic [7:0] idx, val, input logic [1:0] er = 0);
    logic ta, tw, tb, done;
    done = 1'b0;
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h00_0000, val};
    wstrb <= 4'hF;
    bready <= 1'b1;
    for (int i = 0; i < 60 && !done; i++) begin
      @(negedge clock);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      if (tb) chk(8'(bresp), 8'(er), "write response");
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      done = tb;
    end
    if (!done) hang();
  endtask : wr

  // Bus read: low byte of the answer lands in rd
  task automatic rdr(input logic [7:0] idx, input logic [1:0] er = 0);
    logic ta, tr, done;
    done = 1'b0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= {2'b00, idx, 2'b00};
    rready <= 1'b1;
    for (int i = 0; i < 60 && !done; i++) begin
      @(negedge clock);
      ta = arvalid & arready;
      tr = rvalid & rready;
      if (tr) rd = rdata[7:0];
      if (tr) chk(8'(rresp), 8'(er), "read response");
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      done = tr;
    end
    if (!done) hang();
  endtask : rdr

  // Count pulses from the timer source, spaced out
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      timer0Tick <= 1'b1;
      @(posedge clock);
      timer0Tick <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : tick

  task automatic drive_pin(input logic [1:0] v);
    @(posedge clock);
    extLevel <= v;
    repeat (8) @(posedge clock);
  endtask : drive_pin

  task automatic pwm_at(input logic [7:0] c);
    wr(8'hE9, c);
    tick(1);
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : pwm_at

  task automatic s_reset;
    foreach (RST_IDX[k]) begin
      rdr(RST_IDX[k]);
      chk(rd, 8'h00, "reset value");
    end
    rdr(8'h10, 2'b10);
    chk(rd, 8'h00, "unmapped read data");
    wr(8'h10, 8'hFF, 2'b10);
  endtask : s_reset

  task automatic s_regs;
    wr(8'hEA, 8'hA5);
    rdr(8'hEA);
    chk(rd, 8'hA5, "compare byte");
    wr(8'hFB, 8'h5A);
    rdr(8'hFB);
    chk(rd, 8'h5A, "compare byte");
    wr(8'hF2, 8'hFF);
    rdr(8'hF2);
    chk(rd, 8'hC3, "aux reserved bits");
    wr(8'hF2, 8'h00);
  endtask : s_regs

  task automatic s_count;
    wr(8'hD9, 8'h04);
    wr(8'hD8, 8'h40);
    tick(5);
    rdr(8'hE9);
    chk(rd, 8'h05, "count while running");
    wr(8'hD8, 8'h00);
    tick(3);
    rdr(8'hE9);
    chk(rd, 8'h05, "count while stopped");
  endtask : s_count

  task automatic s_overflow;
    wr(8'hE9, 8'hFF);
    wr(8'hF9, 8'hFF);
    wr(8'hD9, 8'h05);
    wr(8'hD8, 8'h40);
    tick(1);
    rdr(8'hF9);
    chk(rd, 8'h00, "count high after wrap");
    rdr(8'hD8);
    chk(rd & 8'h80, 8'h80, "overflow flag");
    @(negedge clock);
    chk(8'(arrayIrq), 8'h01, "overflow irq");
    tick(2);
    rdr(8'hD8);
    chk(rd & 8'h80, 8'h80, "overflow flag sticky");
    wr(8'hD8, 8'h40);
    rdr(8'hD8);
    chk(rd & 8'h80, 8'h00, "overflow flag cleared");
    wr(8'hD9, 8'h04);
  endtask : s_overflow

  task automatic s_capture;
    logic [7:0] m;
    wr(8'hD8, 8'h00);
    wr(8'hF9, 8'h12);
    foreach (CAP_MODE[k]) begin
      m = CAP_MODE[k];
      wr(8'hEA, 8'h00);
      wr(8'hFA, 8'h00);
      wr(8'hDA, m);
      wr(8'hD8, 8'h00);
      wr(8'hE9, 8'h34);
      drive_pin(2'b01);
      rdr(8'hD8);
      chk(rd & 8'h01, 8'(m[5]), "flag after rise");
      wr(8'hE9, 8'h56);
      drive_pin(2'b00);
      rdr(8'hD8);
      chk(rd & 8'h01, 8'(m[5] | m[4]), "flag after fall");
      rdr(8'hEA);
      chk(rd, m[4] ? 8'h56 : m[5] ? 8'h34 : 8'h00, "low");
      rdr(8'hFA);
      chk(rd, (m[5] | m[4]) ? 8'h12 : 8'h00, "high");
    end
  endtask : s_capture

  task automatic s_match;
    wr(8'hE9, 8'h00);
    wr(8'hF9, 8'h00);
    wr(8'hEA, 8'h02);
    wr(8'hEB, 8'h03);
    wr(8'hFB, 8'h00);
    wr(8'hDA, 8'h48);
    wr(8'hDB, 8'h4C);
    wr(8'hD8, 8'h40);
    tick(3);
    rdr(8'hD8);
    chk(rd & 8'hC3, 8'h41, "timer match only");
    tick(1);
    rdr(8'hD8);
    chk(rd & 8'hC3, 8'h43, "both matches");
    @(negedge clock);
    chk(8'(pinOut[1]), 8'h01, "pin toggled");
    chk(8'(pinOe), 8'h02, "pin enables");
    wr(8'hDB, 8'h00);
  endtask : s_match

  task automatic s_pwm;
    logic [1:0] w;
    wr(8'hD8, 8'h40);
    wr(8'hEA, 8'h20);
    wr(8'hFA, 8'h20);
    wr(8'hDA, 8'h42);
    for (int k = 0; k < 4; k++) begin
      w = 2'(k);
      wr(8'hF2, {w, 6'h00});
      pwm_at(8'h90);
      chk(8'(pinOut[0]), 8'(w == 0 || w == 3), "pwm 90");
      pwm_at(8'h50);
      chk(8'(pinOut[0]), 8'(w != 2), "pwm 50");
    end
    chk(8'(pinOe[0]), 8'h01, "pwm drives pin");
    wr(8'hF2, 8'h03);
    pwm_at(8'h90);
    chk(8'(pinOut[0]), 8'h00, "extension bit");
    wr(8'hF2, 8'h00);
    foreach (EDGE_MODE[k]) begin
      wr(8'hDA, EDGE_MODE[k]);
      pwm_at(8'h10);
      wr(8'hD8, 8'h40);
      pwm_at(8'h90);
      chk(8'(arrayIrq), 8'(EDGE_MODE[k][5]), "irq on rise");
      rdr(8'hD8);
      chk(rd & 8'h01, 8'(EDGE_MODE[k][5]), "rise flag");
      wr(8'hD8, 8'h40);
      pwm_at(8'h10);
      rdr(8'hD8);
      chk(rd & 8'h01, 8'(EDGE_MODE[k][4]), "fall flag");
    end
  endtask : s_pwm

  // Main sequence
  initial begin
    n_mismatch = 0;
    check_count = 0;
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, timer0Tick} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    extLevel = '0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    s_reset();
    s_regs();
    s_count();
    s_overflow();
    s_capture();
    s_match();
    s_pwm();
    close_out();
  end
endmodule : cacc_core_tb
`default_nettype wire

// ### verif/cacc_pin_model.sv
// Far-side model of the two module pins
`default_nettype none
module cacc_pin_model (
  input wire logic clock,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  input wire logic [1:0] extLevel,
  output logic [1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wire level: device drive wins, else the outside level
  always @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      pinIn[i] <= pinOe[i] ? pinOut[i] : extLevel[i];
    end
  end
endmodule : cacc_pin_model
`default_nettype wire
